/* core/flash_host_pkg.sv */
// Package: command codes, status bit positions, timing and carrier types for the flash host
package flash_host_pkg;

    // Command codes written on the data bus
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
    localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
    localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;
    localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hB0;

    // Status bit positions
    localparam int SR_READY_BIT     = 7;
    localparam int SR_ERS_SUSP_BIT  = 6;
    localparam int SR_ERASE_ERR_BIT = 5;
    localparam int SR_WRITE_ERR_BIT = 4;
    localparam int SR_SUPPLY_BIT    = 3;
    localparam int SR_WR_SUSP_BIT   = 2;
    localparam int SR_LOCK_BIT      = 1;

    // Bus strobe timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int STROBE_NS         = 100;
    localparam int STROBE_CYCLES     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS        = 40;
    localparam int RECOVER_CYCLES    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_STROBE  = 4'(STROBE_CYCLES);
    localparam logic [3:0] CNT_RECOVER = 4'(RECOVER_CYCLES);

    // Host operations
    typedef enum logic [3:0] {
        OP_NONE         = 4'h0,
        OP_CLEAR_STATUS = 4'h1,
        OP_BLOCK_ERASE  = 4'h2,
        OP_CHIP_ERASE   = 4'h3,
        OP_WRITE        = 4'h4,
        OP_SUSPEND      = 4'h5,
        OP_RESUME       = 4'h6,
        OP_READ_STATUS  = 4'h7,
        OP_READ_ARRAY   = 4'h8,
        OP_READ         = 4'h9
    } op_type;

    typedef struct packed {
        op_type      op;
        logic [19:0] addr;
        logic [15:0] data;
    } request_type;

    // One bus cycle for the strobe engine
    typedef struct packed {
        logic        is_read;
        logic [19:0] addr;
        logic [15:0] data;
    } bus_cycle_type;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [19:0] addr;
        logic [15:0] dq;
        logic        dq_oe_n;
    } pins_type;

endpackage : flash_host_pkg

/* core/flash_bus_cycle.sv */
// Module: one asynchronous flash bus cycle (write or read) driven from the system clock
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          srst_in,
    input  wire logic          start_in,
    input  wire bus_cycle_type cycle_in,
    input  wire logic [15:0]   dq_in,
    output pins_type           pins_out,
    output logic               done_out,
    output logic [15:0]        rdata_out
);
    typedef enum logic [1:0] {
        C_IDLE    = 2'b00,
        C_STROBE  = 2'b01,
        C_RECOVER = 2'b10
    } cstate_type;

    typedef struct packed {
        cstate_type  st;
        logic [3:0]  cnt;
        logic        rd;
        pins_type    pins;
        logic        done;
        logic [15:0] rdata;
    } cyc_state_type;

    cyc_state_type s_reg;
    cyc_state_type s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            C_IDLE: begin
                if (start_in) begin
                    s_next.st           = C_STROBE;
                    s_next.cnt          = CNT_STROBE;
                    s_next.rd           = cycle_in.is_read;
                    s_next.pins.addr    = cycle_in.addr;
                    s_next.pins.dq      = cycle_in.data;
                    s_next.pins.ce_n    = 1'b0;
                    s_next.pins.oe_n    = !cycle_in.is_read;
                    s_next.pins.we_n    = cycle_in.is_read;
                    s_next.pins.dq_oe_n = cycle_in.is_read;
                end
            end
            C_STROBE: begin
                if (s_reg.cnt == 4'h1) begin
                    // Data latched on rising WE; status captured fresh each falling OE
                    s_next.st        = C_RECOVER; // R11 R23
                    s_next.cnt       = CNT_RECOVER;
                    s_next.pins.ce_n = 1'b1;
                    s_next.pins.oe_n = 1'b1;
                    s_next.pins.we_n = 1'b1;
                    if (s_reg.rd) begin
                        s_next.rdata = dq_in;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            C_RECOVER: begin
                s_next.pins.dq_oe_n = 1'b1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.st   = C_IDLE;
                    s_next.done = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            default: s_next.st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_reg              <= '0;
            s_reg.pins.ce_n    <= 1'b1;
            s_reg.pins.oe_n    <= 1'b1;
            s_reg.pins.we_n    <= 1'b1;
            s_reg.pins.dq_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins_out  = s_reg.pins;
    assign done_out  = s_reg.done;
    assign rdata_out = s_reg.rdata;

    // WE high again before any read strobe of a following cycle
    property p_strobe_exclusive;
        @(posedge clk_in) disable iff (srst_in)
        !(s_reg.pins.we_n == 1'b0 && s_reg.pins.oe_n == 1'b0);
    endproperty
    a_strobe_exclusive: assert property (p_strobe_exclusive) // R23
        else $error("write and read strobes low together");

    property p_strobe_rises;
        @(posedge clk_in) disable iff (srst_in)
        $fell(s_reg.pins.we_n) |-> ##[1:8] s_reg.pins.we_n;
    endproperty
    a_strobe_rises: assert property (p_strobe_rises) // R11
        else $error("write strobe never rose");
endmodule : flash_bus_cycle

/* core/flash_host_ctrl.sv */
// Module: host-side controller issuing erase, write, suspend and status commands to a NOR flash
// Function
// [R1] Error flags only clear by clear-status; host never assumes they self clear.
// [R2] Clear-status 50H; host refuses to send it while a suspend is active.
// [R3] Block erase: setup then confirm with an address inside the target block.
// [R4] After erase or write sequence, reads return status until next command.
// [R5] Invalid erase sequence sets write and erase error flags.
// [R6] Erase at low supply sets supply-low and erase error, block untouched.
// [R7] Locked block or boot block with protect low gives lock and erase errors.
// [R8] Full chip erase: write 30H then D0H.
// [R9] Chip erase runs low to high, stops on error, cannot be suspended.
// [R10] Chip erase: all locked gives lock error; bad sequence gives write+erase errors.
// [R11] Word write: 40H or 10H, then address and data, latched on rising strobe.
// [R12] Write at low supply or locked target gives supply or lock plus write error.
// [R13] Verify only catches ones that failed to become zeros.
// [R14] Erase suspend: ready and erase-suspended set, ready/busy floats, status reads.
// [R15] After erase suspend, host writes 70H and checks erase-suspended flag.
// [R16] In erase suspend only read array, write elsewhere, suspend, status, resume.
// [R17] Write under erase suspend clears ready, drives busy, keeps erase-suspended.
// [R18] Erase resume clears suspend and ready flags; waits for nested write.
// [R19] Write suspend: ready and write-suspended set, ready/busy floats.
// [R20] After write suspend, host writes 70H and checks write-suspended flag.
// [R21] In write suspend only read array elsewhere, read status, write resume.
// [R22] Write resume clears write-suspended and ready, continues, status on reads.
// [R23] Status captured on falling read strobe; strobe must rise before next read.
// [R24] Read array ignored while the state machine runs unsuspended.
// [R25] Block erase 20H/D0H; suspend B0H; resumes D0H.
// [R26] Ready/busy low while the state machine executes an operation.
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // System
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // User request port
    input  wire logic        REQ_VALID_IN,
    input  wire request_type REQ_IN,
    output logic             REQ_READY_OUT,
    output logic             DONE_OUT,
    output logic [15:0]      RDATA_OUT,
    output logic [7:0]       STATUS_OUT,
    output logic             REFUSED_OUT,
    output logic             ERS_SUSP_OUT,
    output logic             WR_SUSP_OUT,
    // Flash pins
    input  wire logic        READY_BUSY_IN,
    input  wire logic [15:0] DQ_IN,
    output logic             CE_N_OUT,
    output logic             OE_N_OUT,
    output logic             WE_N_OUT,
    output logic [19:0]      ADDR_OUT,
    output logic [15:0]      DQ_OUT,
    output logic             DQ_OE_N_OUT,
    output logic             RESET_POWERDOWN_N_OUT
);
    typedef enum logic [2:0] {
        H_IDLE   = 3'b000,
        H_ISSUE  = 3'b001,
        H_WAIT   = 3'b010,
        H_POLL   = 3'b011,
        H_FINISH = 3'b100
    } hstate_type;

    typedef struct packed {
        hstate_type    st;
        request_type   req;
        logic [1:0]    step;
        logic [1:0]    steps;
        logic          poll;
        logic          start;
        bus_cycle_type cyc;
        logic          ready;
        logic          done;
        logic          refused;
        logic [15:0]   rdata;
        logic [7:0]    status;
        logic          ers_susp;
        logic          wr_susp;
        logic          rp_n;
    } host_state_type;

    host_state_type s_reg;
    host_state_type s_next;
    pins_type       pins;
    logic           cyc_done;
    logic [15:0]    cyc_rdata;

    flash_bus_cycle u_cycle (
        .clk_in    (CLK_IN),
        .srst_in   (SRST_IN),
        .start_in  (s_reg.start),
        .cycle_in  (s_reg.cyc),
        .dq_in     (DQ_IN),
        .pins_out  (pins),
        .done_out  (cyc_done),
        .rdata_out (cyc_rdata)
    );

    // Bus cycle number n of the current operation
    function automatic bus_cycle_type cycle_for(request_type r, logic [1:0] n);
        bus_cycle_type c;
        c         = '0;
        c.addr    = r.addr;
        c.is_read = 1'b0;
        unique case (r.op)
            OP_CLEAR_STATUS: c.data = {8'h00, CMD_CLEAR_STATUS}; // R2 R1
            OP_BLOCK_ERASE:  c.data = {8'h00, (n == 2'd0) ? CMD_BLOCK_ERASE
                                                          : CMD_CONFIRM}; // R3 R25
            OP_CHIP_ERASE:   c.data = {8'h00, (n == 2'd0) ? CMD_CHIP_ERASE : CMD_CONFIRM}; // R8
            OP_WRITE:        c.data = (n == 2'd0) ? {8'h00, CMD_WRITE_SETUP} : r.data; // R11
            OP_SUSPEND:      c.data = (n == 2'd0) ? {8'h00, CMD_SUSPEND}
                                                  : {8'h00, CMD_READ_STATUS}; // R25 R15 R20
            OP_RESUME:       c.data = {8'h00, CMD_CONFIRM}; // R18 R22
            OP_READ_STATUS:  c.data = {8'h00, CMD_READ_STATUS};
            OP_READ_ARRAY:   c.data = {8'h00, CMD_READ_ARRAY};
            OP_READ:         c.is_read = 1'b1;
            default:         c.data = 16'h0000;
        endcase
        if (r.op == OP_SUSPEND && n == 2'd2) begin
            c.is_read = 1'b1;
        end
        return c;
    endfunction

    function automatic logic [1:0] steps_for(op_type op);
        unique case (op)
            OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_WRITE: steps_for = 2'd2;
            OP_SUSPEND:                              steps_for = 2'd3;
            default:                                 steps_for = 2'd1;
        endcase
    endfunction

    logic allowed;
    always_comb begin
        // Commands the flash would ignore in its current mode are refused here
        unique case (REQ_IN.op)
            OP_CLEAR_STATUS: allowed = !s_reg.ers_susp && !s_reg.wr_susp; // R2
            OP_BLOCK_ERASE,
            OP_CHIP_ERASE:   allowed = !s_reg.ers_susp && !s_reg.wr_susp; // R9 R16
            OP_WRITE:        allowed = !s_reg.wr_susp; // R16 R21
            OP_SUSPEND:      allowed = !s_reg.wr_susp;
            OP_RESUME:       allowed = s_reg.ers_susp || s_reg.wr_susp;
            OP_NONE:         allowed = 1'b0;
            default:         allowed = 1'b1;
        endcase
    end

    always_comb begin
        s_next         = s_reg;
        s_next.start   = 1'b0;
        s_next.done    = 1'b0;
        s_next.refused = 1'b0;
        s_next.rp_n    = 1'b1;
        unique case (s_reg.st)
            H_IDLE: begin
                if (REQ_VALID_IN && s_reg.ready) begin
                    s_next.ready = 1'b0;
                    if (allowed) begin
                        s_next.req   = REQ_IN;
                        s_next.step  = 2'd0;
                        s_next.steps = steps_for(REQ_IN.op);
                        s_next.poll  = 1'b0;
                        s_next.st    = H_ISSUE;
                    end else begin
                        s_next.refused = 1'b1;
                        s_next.st      = H_FINISH;
                    end
                end
            end
            H_ISSUE: begin
                s_next.start = 1'b1;
                s_next.cyc   = s_reg.poll ? bus_cycle_type'{1'b1, s_reg.req.addr, 16'h0000}
                                          : cycle_for(s_reg.req, s_reg.step);
                s_next.st    = H_WAIT;
            end
            H_WAIT: begin
                if (cyc_done) begin
                    if (s_reg.cyc.is_read) begin
                        s_next.rdata  = cyc_rdata;
                        s_next.status = cyc_rdata[7:0];
                    end
                    if (!s_reg.poll && s_reg.step + 2'd1 < s_reg.steps) begin
                        s_next.step = s_reg.step + 2'd1;
                        s_next.st   = H_ISSUE;
                    end else if (s_reg.req.op inside {OP_BLOCK_ERASE, OP_CHIP_ERASE,
                                                      OP_WRITE, OP_RESUME}) begin
                        s_next.st = H_POLL; // R4
                    end else begin
                        s_next.st = H_FINISH;
                    end
                end
            end
            H_POLL: begin
                // Status reads until ready; a rising busy line alone is not trusted
                if (s_reg.poll && s_reg.status[SR_READY_BIT] && READY_BUSY_IN) begin // R26
                    s_next.st = H_FINISH;
                end else begin
                    s_next.poll = 1'b1; // R4 R23
                    s_next.st   = H_ISSUE;
                end
            end
            H_FINISH: begin
                s_next.done  = 1'b1;
                s_next.ready = 1'b1;
                s_next.st    = H_IDLE;
                if (!s_reg.refused && s_reg.req.op == OP_SUSPEND) begin
                    // Suspend counts only if the flag is seen after 70H
                    if (s_reg.wr_susp == 1'b0 && s_reg.ers_susp
                            && s_reg.status[SR_WR_SUSP_BIT]) begin
                        s_next.wr_susp = 1'b1; // R20
                    end else if (s_reg.status[SR_ERS_SUSP_BIT]) begin
                        s_next.ers_susp = 1'b1; // R15
                    end else begin
                        s_next.wr_susp = s_reg.status[SR_WR_SUSP_BIT]; // R20
                    end
                end else if (!s_reg.refused && s_reg.req.op == OP_RESUME) begin
                    if (s_reg.wr_susp) begin
                        s_next.wr_susp = 1'b0; // R22
                    end else begin
                        s_next.ers_susp = 1'b0; // R18
                    end
                end
            end
            default: s_next.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            s_reg       <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign REQ_READY_OUT         = s_reg.ready;
    assign DONE_OUT              = s_reg.done;
    assign RDATA_OUT             = s_reg.rdata;
    assign STATUS_OUT            = s_reg.status;
    assign REFUSED_OUT           = s_reg.refused;
    assign ERS_SUSP_OUT          = s_reg.ers_susp;
    assign WR_SUSP_OUT           = s_reg.wr_susp;
    assign RESET_POWERDOWN_N_OUT = s_reg.rp_n;
    assign CE_N_OUT              = pins.ce_n;
    assign OE_N_OUT              = pins.oe_n;
    assign WE_N_OUT              = pins.we_n;
    assign ADDR_OUT              = pins.addr;
    assign DQ_OUT                = pins.dq;
    assign DQ_OE_N_OUT           = pins.dq_oe_n;

    property p_no_clear_in_suspend;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_ISSUE && s_reg.req.op == OP_CLEAR_STATUS)
        |-> !s_reg.ers_susp && !s_reg.wr_susp;
    endproperty
    a_no_clear_in_suspend: assert property (p_no_clear_in_suspend) // R2
        else $error("clear status issued during suspend");

    property p_no_erase_in_suspend;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_ISSUE && s_reg.req.op inside {OP_CHIP_ERASE, OP_BLOCK_ERASE})
        |-> !s_reg.ers_susp;
    endproperty
    a_no_erase_in_suspend: assert property (p_no_erase_in_suspend) // R16
        else $error("erase issued while erase suspended");

    property p_no_write_in_wsusp;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_ISSUE && s_reg.req.op == OP_WRITE) |-> !s_reg.wr_susp;
    endproperty
    a_no_write_in_wsusp: assert property (p_no_write_in_wsusp) // R21
        else $error("write issued while write suspended");

    property p_finish_needs_ready;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_POLL && $past(s_reg.st) == H_WAIT && s_reg.req.op == OP_WRITE) ##1
        (s_reg.st == H_FINISH) |-> $past(s_reg.status[SR_READY_BIT]);
    endproperty
    a_finish_needs_ready: assert property (p_finish_needs_ready) // R4
        else $error("write finished without ready status");

    property p_refuse_pulse;
        @(posedge CLK_IN) disable iff (SRST_IN)
        s_reg.refused |=> s_reg.done ##1 !s_reg.done;
    endproperty
    a_refuse_pulse: assert property (p_refuse_pulse) // R16
        else $error("refused request not completed");

    property p_resume_clears;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_FINISH && s_reg.req.op == OP_RESUME && !s_reg.refused && s_reg.wr_susp)
        |=> !s_reg.wr_susp;
    endproperty
    a_resume_clears: assert property (p_resume_clears) // R22
        else $error("write suspend not cleared on resume");

    property p_setup_codes;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_ISSUE && !s_reg.poll && s_reg.step == 2'd0 && s_reg.req.op == OP_CHIP_ERASE)
        |=> s_reg.cyc.data[7:0] == CMD_CHIP_ERASE;
    endproperty
    a_setup_codes: assert property (p_setup_codes) // R8
        else $error("wrong chip erase setup code");

    property p_confirm_code;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (s_reg.st == H_ISSUE && !s_reg.poll && s_reg.step == 2'd1 && s_reg.req.op == OP_BLOCK_ERASE)
        |=> s_reg.cyc.data[7:0] == CMD_CONFIRM && s_reg.cyc.addr == s_reg.req.addr;
    endproperty
    a_confirm_code: assert property (p_confirm_code) // R3
        else $error("bad erase confirm cycle");
endmodule : flash_host_ctrl

/* tb/flash_model.sv */
// Behavioural flash device: command decoder, status flags, tiny array
module flash_model
    import flash_host_pkg::*;
#(
    parameter int BUSY_CYCLES = 20
)(
    input  wire logic        clk_in,
    input  wire logic        rp_n_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        low_supply_in,
    input  wire logic        locked_in,
    output logic [15:0]      dq_out,
    output logic             ready_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] latch_reg = 16'h0000;
    logic [7:0]  status_reg = 8'h00;
    logic [7:0]  setup_reg = 8'h00;
    logic        stat_mode = 1'b0;
    logic        wr_reg = 1'b0;
    logic        chip_reg = 1'b0;
    logic        susp;
    logic        halted;
    int          busy = 0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    assign susp = status_reg[6] | status_reg[2];
    // Floating output reads as pulled up
    // A write nested in erase suspend still runs and reports busy
    assign halted = status_reg[2] | (status_reg[6] & !wr_reg);
    assign ready_busy_out = (busy == 0) || halted;
    always @(posedge clk_in) if (busy > 0 && !halted) busy <= busy - 1;
    always @(negedge rp_n_in) begin
        status_reg = 8'h00;
        busy = 0;
        stat_mode = 1'b0;
        setup_reg = 8'h00;
    end
    // Write strobe edges while held in reset are ignored; a falling OE still latches
    always @(posedge we_n_in) if (rp_n_in === 1'b1) begin
        stat_mode = 1'b1;
        if (setup_reg == CMD_WRITE_SETUP || setup_reg == CMD_WRITE_ALT) begin
            if (low_supply_in || locked_in)
                status_reg |= 8'h10 | {4'h0, low_supply_in, 1'h0, locked_in, 1'h0};
            else begin
                mem[addr_in[3:0]] &= dq_in;
                busy = BUSY_CYCLES;
                wr_reg = 1'b1;
            end
            setup_reg = 8'h00;
        end else if (setup_reg == CMD_BLOCK_ERASE || setup_reg == CMD_CHIP_ERASE) begin
            if (dq_in[7:0] != CMD_CONFIRM)
                status_reg |= 8'h30;
            else if (low_supply_in || locked_in)
                status_reg |= 8'h20 | {4'h0, low_supply_in, 1'h0, locked_in, 1'h0};
            else begin
                for (int i = 0; i < 16; i++)
                    if (setup_reg == CMD_CHIP_ERASE || i[3:2] == addr_in[3:2])
                        mem[i] = 16'hFFFF;
                busy = BUSY_CYCLES;
                wr_reg = 1'b0;
                chip_reg = (setup_reg == CMD_CHIP_ERASE);
            end
            setup_reg = 8'h00;
        end else
            case (dq_in[7:0])
                CMD_CLEAR_STATUS: if (!susp) status_reg &= 8'hC5;
                CMD_READ_ARRAY: if (busy == 0 || susp) stat_mode = 1'b0;
                CMD_SUSPEND: if (busy == 0) stat_mode = 1'b0;
                    else if (!chip_reg) status_reg[wr_reg ? 2 : 6] = 1'b1;
                CMD_CONFIRM: status_reg &= 8'hBB;
                CMD_READ_STATUS: ;
                default: setup_reg = dq_in[7:0];
            endcase
    end
    always @(negedge oe_n_in)
        latch_reg = stat_mode ? {8'h00, busy == 0 || halted, status_reg[6:0]} : mem[addr_in[3:0]];
    // Released bus shows the inverse so stale data never matches
    assign dq_out = (!ce_n_in && !oe_n_in) ? latch_reg : ~latch_reg;
endmodule : flash_model

/* tb/testbench.sv */
// Self-checking bench for the flash host controller against the device model
module testbench
    import flash_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        op_type      op;
        logic [3:0]  a;
        logic [15:0] d;
        logic [1:0]  env;
        logic [15:0] exp;
        logic        rf;
    } row_type;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        req_valid = 1'b0;
    request_type req = '0;
    logic        low_supply = 1'b0;
    logic        locked = 1'b0;
    logic        saw_ref, req_ready, done, refused, ers_susp, wr_susp, rb;
    logic        ce_n, oe_n, we_n, dq_oe_n, rp_n;
    logic [15:0] rdata, dq_host, dq_dev, dq_bus;
    logic [7:0]  status;
    logic [19:0] addr;
    int          n_errors = 0;
    int          comparisons = 0;
    row_type     rows [16] = '{
        '{OP_WRITE,        4'h5, 16'h1234, 2'h0, 16'h0080, 1'h0},
        '{OP_READ_ARRAY,   4'h0, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_READ,         4'h5, 16'h0000, 2'h0, 16'h1234, 1'h0},
        '{OP_WRITE,        4'h5, 16'hFF00, 2'h0, 16'h0080, 1'h0},
        '{OP_BLOCK_ERASE,  4'h9, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_READ_ARRAY,   4'h0, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_READ,         4'h5, 16'h0000, 2'h0, 16'h1200, 1'h0},
        '{OP_CHIP_ERASE,   4'h0, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_READ_ARRAY,   4'h0, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_READ,         4'h5, 16'h0000, 2'h0, 16'hFFFF, 1'h0},
        '{OP_SUSPEND,      4'h0, 16'h0000, 2'h0, 16'h0080, 1'h0},
        '{OP_RESUME,       4'h0, 16'h0000, 2'h0, 16'h0080, 1'h1},
        '{OP_BLOCK_ERASE,  4'h1, 16'h0000, 2'h2, 16'h00A8, 1'h0},
        '{OP_WRITE,        4'h1, 16'h0000, 2'h2, 16'h00B8, 1'h0},
        '{OP_CLEAR_STATUS, 4'h0, 16'h0000, 2'h0, 16'h00B8, 1'h0},
        '{OP_BLOCK_ERASE,  4'h1, 16'h0000, 2'h1, 16'h00A2, 1'h0}
    };
    always #20 clk = ~clk;
    assign dq_bus = dq_oe_n ? dq_dev : dq_host;
    flash_host_ctrl flash_host_ctrl_i (.CLK_IN(clk), .SRST_IN(srst), .REQ_VALID_IN(req_valid),
        .REQ_IN(req), .REQ_READY_OUT(req_ready), .DONE_OUT(done), .RDATA_OUT(rdata),
        .STATUS_OUT(status), .REFUSED_OUT(refused), .ERS_SUSP_OUT(ers_susp),
        .WR_SUSP_OUT(wr_susp), .READY_BUSY_IN(rb), .DQ_IN(dq_bus), .CE_N_OUT(ce_n),
        .OE_N_OUT(oe_n), .WE_N_OUT(we_n), .ADDR_OUT(addr), .DQ_OUT(dq_host),
        .DQ_OE_N_OUT(dq_oe_n), .RESET_POWERDOWN_N_OUT(rp_n));
    flash_model flash_model_i (.clk_in(clk), .rp_n_in(rp_n), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .addr_in(addr), .dq_in(dq_bus), .low_supply_in(low_supply),
        .locked_in(locked), .dq_out(dq_dev), .ready_busy_out(rb));
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check16
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit
    task automatic run(input op_type op, input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, a, d};
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        saw_ref = 1'b0;
        for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
            @(posedge clk);
            if (refused === 1'b1) saw_ref = 1'b1;
        end
        check_bit(done, 1'b1);
    endtask : run
    task automatic tally_and_finish;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        check_bit(rp_n, 1'b1);
        foreach (rows[i]) begin
            {low_supply, locked} <= rows[i].env;
            run(rows[i].op, {16'h0000, rows[i].a}, rows[i].d);
            check16(rdata, rows[i].exp);
            check_bit(saw_ref, rows[i].rf);
            $display("row %0d done", i);
        end
        check16({8'h00, status}, rows[15].exp);
        check_bit(ers_susp, 1'b0);
        check_bit(wr_susp, 1'b0);
        // Second reset mid-run: strobes idle, device held in reset
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        check16(16'({ce_n, oe_n, we_n, dq_oe_n, rp_n}), 16'h001E);
        srst <= 1'b0;
        run(OP_READ_STATUS, 20'h00000, 16'h0000);
        run(OP_READ, 20'h00000, 16'h0000);
        check16(rdata, 16'h0080);
        $display("reset test done");
        tally_and_finish();
    end
endmodule : testbench
